//--- strap_pkg.sv
// constants and load state encoding for the reset configuration loader
package strap_pkg;
	localparam int STRAP_W = 24;
	localparam int SYNC_W = 2;
	localparam logic [7:0] ADDR_BUS_MEM = 8'h00;
	localparam logic [7:0] ADDR_TEST_CLK = 8'h01;
	localparam logic [7:0] ADDR_MONITOR = 8'h02;
	localparam logic [7:0] ADDR_STATUS = 8'h03;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [23:0] STRAP_RST = 24'h000000;
	localparam int REG0_LO = 0;
	localparam int REG1_LO = 8;
	localparam int MON2_LO = 20;
	localparam int MON2_W = 3;
	localparam int STRAP_TEST_BIT = 9;
	localparam int BUS_LO = 0;
	localparam int PAGE_LO = 2;
	localparam int ROM_EN_BIT = 4;
	localparam int SIZE_LO = 5;
	localparam int EN_BIT = 0;
	localparam int TEST_BIT = 1;
	localparam int ROM_SIZE_BIT = 2;
	localparam int CLK_SEL_BIT = 3;
	localparam int PAL_SNOOP_BIT = 4;
	localparam logic [1:0] BUS_VL = 2'h1;
	localparam logic [1:0] BUS_PCI = 2'h2;
	localparam logic [1:0] PAGE_EDO = 2'h2;
	localparam logic [1:0] PAGE_FAST = 2'h3;
	localparam logic [2:0] SIZE_4M = 3'h0;
	localparam logic [2:0] SIZE_2M = 3'h4;
	localparam logic [2:0] SIZE_1M = 3'h6;
	localparam logic [2:0] SIZE_HALF = 3'h7;
	localparam logic [1:0] RAS_IDLE = 2'h3;
	localparam logic [7:0] CAS_IDLE = 8'hFF;
	localparam logic [1:0] OE_IDLE = 2'h3;
	localparam logic [8:0] ADDR_IDLE = 9'h000;
	typedef enum logic [1:0] {LD_RESET, LD_CAPTURE, LD_RUN} load_state_e;
endpackage

//--- reset_strap_config_loader.sv
// reset handling, strap capture, configuration registers and pin control
`timescale 1ns/1ps
// Functional notes
// - reset clears state and restores register defaults
// - sample all 24 strap pins at reset release
// - strap pins act as pixel bus after reset
// - bits 1-0 select PCI or local bus
// - bits 3-2 select EDO or fast page
// - local bus bit 4 enables firmware ROM decode
// - bits 7-5 encode display memory size
// - memory size field stays software writable
// - local bus bit 8 low: ROM cycles only
// - bit 9 low enters test mode, all tristated
// - reset holds memory strobes and address idle, driven unless bit 9 is low
// - bit 11 selects internal or external clocks
// - local bus bit 12 gates palette write claims
// - capture monitor bits uninterpreted
module reset_strap_config_loader
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [strap_pkg::STRAP_W-1:0] pixel_data_strap_pins,
	output logic [strap_pkg::STRAP_W-1:0] pixel_data_out,
	output logic [strap_pkg::STRAP_W-1:0] pixel_data_oe,
	input wire logic [strap_pkg::STRAP_W-1:0] pix_src_data,
	input wire logic pix_src_en,
	input wire logic [1:0] mem_ras_n_in,
	input wire logic [7:0] mem_cas_n_in,
	input wire logic mem_we_n_in,
	input wire logic [1:0] mem_oe_n_in,
	input wire logic [8:0] mem_addr_in,
	output logic [1:0] mem_ras_n,
	output logic [7:0] mem_cas_n,
	output logic mem_we_n,
	output logic [1:0] mem_oe_n,
	output logic [8:0] memory_address_out,
	output logic mem_ctrl_oe,
	input wire logic cyc_req,
	input wire logic cyc_rom,
	input wire logic cyc_pal_wr,
	output logic cyc_accept,
	output logic local_bus_claim,
	output logic local_bus_claim_oe,
	output logic local_bus_ready_out,
	output logic local_bus_ready_oe,
	output logic host_bus_pci,
	output logic host_bus_vl,
	output logic host_bus_bad,
	output logic page_edo,
	output logic page_fast,
	output logic page_bad,
	output logic rom_decode_en,
	output logic rom_size_32k,
	output logic [2:0] mem_size_code,
	output logic mem_size_bad,
	output logic clk_sel_internal,
	output logic test_mode,
	output logic strap_done
);
	import strap_pkg::*;

	logic [STRAP_W-1:0] cap_val;
	logic cap_pulse;
	logic in_reset;
	logic test_pin_sync;
	logic [7:0] bus_mem_r;
	logic [7:0] test_clk_r;
	logic [MON2_W-1:0] monitor_r;
	logic done_r;
	logic [7:0] rdata_r;
	logic [7:0] rd_nxt;
	logic [7:0] status_w;
	logic is_vl;
	logic allow;
	logic tm;
	logic [STRAP_W-1:0] pd_out_r;
	logic [STRAP_W-1:0] pd_oe_r;
	logic [1:0] ras_r;
	logic [7:0] cas_r;
	logic we_r;
	logic [1:0] oe_r;
	logic [8:0] ma_r;
	logic mem_oe_r;
	logic accept_r;
	logic claim_r;
	logic claim_oe_r;
	logic ready_r;
	logic ready_oe_r;
	logic pci_r;
	logic vl_r;
	logic bus_bad_r;
	logic edo_r;
	logic fast_r;
	logic page_bad_r;
	logic rom_en_r;
	logic rom32_r;
	logic [2:0] size_r;
	logic size_bad_r;
	logic clk_int_r;
	logic tm_r;

	// synchronises the strap pins and catches them at reset release
	strap_capture u_cap
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.pins(pixel_data_strap_pins),
		.cap_val(cap_val),
		.cap_pulse(cap_pulse),
		.in_reset(in_reset),
		.test_pin_sync(test_pin_sync)
	);

	// configuration registers: loaded once at release, then software owned
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			bus_mem_r <= REG_RST;
		else if (cap_pulse)
			bus_mem_r <= cap_val[REG0_LO +: 8];
		else if (reg_wr && reg_addr == ADDR_BUS_MEM)
			bus_mem_r <= reg_wdata;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			test_clk_r <= REG_RST;
		else if (cap_pulse)
			test_clk_r <= cap_val[REG1_LO +: 8];
		else if (reg_wr && reg_addr == ADDR_TEST_CLK)
			test_clk_r <= reg_wdata;
	end

	// upper monitor bits are stored as captured, never decoded
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			monitor_r <= MON2_W'(REG_RST);
		else if (cap_pulse)
			monitor_r <= cap_val[MON2_LO +: MON2_W];
		else if (reg_wr && reg_addr == ADDR_MONITOR)
			monitor_r <= reg_wdata[MON2_W-1:0];
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			done_r <= 1'b0;
		else if (cap_pulse)
			done_r <= 1'b1;
	end

	// read port: data valid only in the cycle after the strobe
	assign status_w = {4'h0, bus_bad_r, page_bad_r, tm_r, done_r};

	always_comb
	begin
		rd_nxt = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				ADDR_BUS_MEM: rd_nxt = bus_mem_r;
				ADDR_TEST_CLK: rd_nxt = test_clk_r;
				ADDR_MONITOR: rd_nxt = {5'h00, monitor_r};
				ADDR_STATUS: rd_nxt = status_w;
				default: rd_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			rdata_r <= 8'h00;
		else
			rdata_r <= rd_nxt;
	end

	// field decode
	assign is_vl = bus_mem_r[BUS_LO +: 2] == BUS_VL;
	assign tm = ~test_clk_r[TEST_BIT];

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pci_r <= 1'b0;
			vl_r <= 1'b0;
			bus_bad_r <= 1'b0;
		end
		else
		begin
			pci_r <= bus_mem_r[BUS_LO +: 2] == BUS_PCI;
			vl_r <= is_vl;
			bus_bad_r <= !(is_vl || bus_mem_r[BUS_LO +: 2] == BUS_PCI);
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			edo_r <= 1'b0;
			fast_r <= 1'b0;
			page_bad_r <= 1'b0;
		end
		else
		begin
			edo_r <= bus_mem_r[PAGE_LO +: 2] == PAGE_EDO;
			fast_r <= bus_mem_r[PAGE_LO +: 2] == PAGE_FAST;
			page_bad_r <= !bus_mem_r[PAGE_LO + 1];
		end
	end

	// firmware ROM decode is only strap controlled on the local bus
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rom_en_r <= 1'b0;
			rom32_r <= 1'b0;
		end
		else
		begin
			rom_en_r <= !is_vl || bus_mem_r[ROM_EN_BIT];
			rom32_r <= test_clk_r[ROM_SIZE_BIT];
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			size_r <= SIZE_4M;
			size_bad_r <= 1'b0;
		end
		else
		begin
			size_r <= bus_mem_r[SIZE_LO +: 3];
			case (bus_mem_r[SIZE_LO +: 3])
				SIZE_4M, SIZE_2M, SIZE_1M, SIZE_HALF:
					size_bad_r <= 1'b0;
				default:
					size_bad_r <= 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			clk_int_r <= 1'b0;
			tm_r <= 1'b0;
		end
		else
		begin
			clk_int_r <= test_clk_r[CLK_SEL_BIT];
			tm_r <= done_r && tm;
		end
	end

	// host cycle filter and local bus claim
	always_comb
	begin
		allow = 1'b1;
		if (is_vl && !test_clk_r[EN_BIT])
			allow = cyc_rom;
		if (is_vl && cyc_pal_wr && !test_clk_r[PAL_SNOOP_BIT])
			allow = 1'b0;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			accept_r <= 1'b0;
			claim_r <= 1'b0;
			ready_r <= 1'b0;
		end
		else
		begin
			accept_r <= done_r && cyc_req && allow;
			claim_r <= done_r && is_vl && cyc_req && allow;
			ready_r <= claim_r;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			claim_oe_r <= 1'b0;
			ready_oe_r <= 1'b0;
		end
		else
		begin
			claim_oe_r <= done_r && is_vl && !tm;
			ready_oe_r <= done_r && is_vl && !tm;
		end
	end

	// pixel bus: normal use after release, strap values irrelevant
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pd_out_r <= STRAP_RST;
			pd_oe_r <= STRAP_RST;
		end
		else
		begin
			pd_out_r <= pix_src_data;
			pd_oe_r <= {STRAP_W{done_r && pix_src_en && !tm}};
		end
	end

	// memory strobes and address held at idle levels through reset
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ras_r <= RAS_IDLE;
			cas_r <= CAS_IDLE;
			we_r <= 1'b1;
			oe_r <= OE_IDLE;
			ma_r <= ADDR_IDLE;
		end
		else
		begin
			ras_r <= mem_ras_n_in;
			cas_r <= mem_cas_n_in;
			we_r <= mem_we_n_in;
			oe_r <= mem_oe_n_in;
			ma_r <= mem_addr_in;
		end
	end

	// enable follows the live test pin until the fields are loaded
	always_ff @(posedge clk)
	begin
		if (in_reset || !done_r)
			mem_oe_r <= test_pin_sync;
		else
			mem_oe_r <= !tm;
	end

	assign reg_rdata = rdata_r;
	assign pixel_data_out = pd_out_r;
	assign pixel_data_oe = pd_oe_r;
	assign mem_ras_n = ras_r;
	assign mem_cas_n = cas_r;
	assign mem_we_n = we_r;
	assign mem_oe_n = oe_r;
	assign memory_address_out = ma_r;
	assign mem_ctrl_oe = mem_oe_r;
	assign cyc_accept = accept_r;
	assign local_bus_claim = claim_r;
	assign local_bus_claim_oe = claim_oe_r;
	assign local_bus_ready_out = ready_r;
	assign local_bus_ready_oe = ready_oe_r;
	assign host_bus_pci = pci_r;
	assign host_bus_vl = vl_r;
	assign host_bus_bad = bus_bad_r;
	assign page_edo = edo_r;
	assign page_fast = fast_r;
	assign page_bad = page_bad_r;
	assign rom_decode_en = rom_en_r;
	assign rom_size_32k = rom32_r;
	assign mem_size_code = size_r;
	assign mem_size_bad = size_bad_r;
	assign clk_sel_internal = clk_int_r;
	assign test_mode = tm_r;
	assign strap_done = done_r;
endmodule

// strap pin synchroniser and release-edge capture
module strap_capture
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [strap_pkg::STRAP_W-1:0] pins,
	output logic [strap_pkg::STRAP_W-1:0] cap_val,
	output logic cap_pulse,
	output logic in_reset,
	output logic test_pin_sync
);
	import strap_pkg::*;

	logic [STRAP_W-1:0] s1_r;
	logic [STRAP_W-1:0] s2_r;
	logic [STRAP_W-1:0] cap_r;
	load_state_e st_r;

	// synchroniser runs through reset so pin levels are ready at release
	always_ff @(posedge clk)
	begin
		s1_r <= pins;
		s2_r <= s1_r;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			st_r <= LD_RESET;
		else
		begin
			case (st_r)
				LD_RESET: st_r <= LD_CAPTURE;
				LD_CAPTURE: st_r <= LD_RUN;
				LD_RUN: st_r <= LD_RUN;
				default: st_r <= LD_RUN;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			cap_r <= STRAP_RST;
		else if (st_r == LD_RESET)
			cap_r <= s2_r;
	end

	assign cap_val = cap_r;
	assign cap_pulse = st_r == LD_CAPTURE;
	assign in_reset = st_r == LD_RESET;
	assign test_pin_sync = s2_r[STRAP_TEST_BIT];
endmodule

//--- strap_loader_chk_sva.sv
// assertion checker for the reset configuration loader
`timescale 1ns/1ps
module strap_loader_chk
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_rdata,
	input wire logic cyc_req,
	input wire logic cyc_accept,
	input wire logic local_bus_claim,
	input wire logic local_bus_ready_out,
	input wire logic [strap_pkg::STRAP_W-1:0] pix_src_data,
	input wire logic [strap_pkg::STRAP_W-1:0] pixel_data_out,
	input wire logic [8:0] mem_addr_in,
	input wire logic [8:0] memory_address_out,
	input wire logic host_bus_pci,
	input wire logic host_bus_vl,
	input wire logic test_mode,
	input wire logic strap_done
);
	import strap_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence claim_s;
		local_bus_claim ##1 local_bus_ready_out;
	endsequence
	a_claim_ready: assert property (local_bus_claim |-> claim_s)
		else $error("ready did not follow claim");
	a_claim_accept: assert property (local_bus_claim |-> cyc_accept)
		else $error("claim without accept");
	a_accept_cause: assert property (cyc_accept |-> $past(cyc_req))
		else $error("accept without request");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	a_bus_onehot: assert property (!(host_bus_pci && host_bus_vl))
		else $error("both bus types selected");
	a_done_held: assert property ($past(strap_done) |-> strap_done)
		else $error("capture done dropped");
	a_strap_hold: assert property ($past(strap_done, 2) && !$past(reg_wr, 2)
		|-> $stable(host_bus_pci) && $stable(test_mode))
		else $error("captured field changed without write");
	a_pix_follow: assert property ($past(strap_done)
		|-> pixel_data_out == $past(pix_src_data))
		else $error("pixel data not passed through");
	a_addr_follow: assert property ($past(strap_done)
		|-> memory_address_out == $past(mem_addr_in))
		else $error("memory address not passed through");
endmodule
bind reset_strap_config_loader strap_loader_chk u_chk (.clk, .sys_rst,
	.reg_rd, .reg_wr, .reg_rdata, .cyc_req, .cyc_accept, .local_bus_claim,
	.local_bus_ready_out, .pix_src_data, .pixel_data_out, .mem_addr_in,
	.memory_address_out, .host_bus_pci, .host_bus_vl, .test_mode,
	.strap_done);

//--- strap_board.sv
// board strap resistors and pixel pin wiring
`timescale 1ns/1ps
module strap_board
(
	input wire logic [23:0] strap_lvl,
	input wire logic [23:0] drv_val,
	input wire logic [23:0] drv_oe,
	output logic [23:0] pin_lvl
);
	// a released pin settles to its resistor level
	always_comb
	begin
		for (int i = 0; i < 24; i++)
		begin
			pin_lvl[i] = drv_oe[i] ? drv_val[i] : strap_lvl[i];
		end
	end
endmodule

//--- test_reset_strap_config_loader.sv
// self-checking testbench for the reset configuration loader
`timescale 1ns/1ps
module test_reset_strap_config_loader;
	import strap_pkg::*;
	logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, pix_src_en = 0;
	logic cyc_req = 0, cyc_rom = 0, cyc_pal_wr = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [23:0] strap = 24'h000000, pins, pix_src_data = 24'h000000;
	logic [23:0] pix_out, pix_oe;
	logic [21:0] mem_in = 22'h2AAAAA;
	logic [1:0] ras_n;
	logic ctrl_oe, acc, claim, rdy, pci, vl, edo, fast, pbad, rom_en;
	logic clk_int, tmode, done;
	logic [2:0] size;
	logic [8:0] ma_o;
	logic [1:0] oe_o;
	logic [7:0] cas_o;
	logic we_o, hbad, szbad, rom32, claim_oe, ready_oe;
	int n_fail = 0, check_count = 0, cyc_n = 0;
	strap_board board (.strap_lvl(strap), .drv_val(pix_out),
		.drv_oe(pix_oe), .pin_lvl(pins));
	reset_strap_config_loader dut (.clk, .sys_rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .pixel_data_strap_pins(pins),
		.pixel_data_out(pix_out), .pixel_data_oe(pix_oe), .pix_src_data,
		.pix_src_en, .mem_ras_n_in(mem_in[1:0]), .mem_cas_n_in(mem_in[9:2]),
		.mem_we_n_in(mem_in[10]), .mem_oe_n_in(mem_in[12:11]),
		.mem_addr_in(mem_in[21:13]), .mem_ras_n(ras_n), .mem_cas_n(cas_o),
		.mem_we_n(we_o), .mem_oe_n(oe_o), .memory_address_out(ma_o),
		.mem_ctrl_oe(ctrl_oe),
		.cyc_req, .cyc_rom, .cyc_pal_wr, .cyc_accept(acc),
		.local_bus_claim(claim), .local_bus_claim_oe(claim_oe),
		.local_bus_ready_out(rdy), .local_bus_ready_oe(ready_oe),
		.host_bus_pci(pci), .host_bus_vl(vl), .host_bus_bad(hbad),
		.page_edo(edo), .page_fast(fast),
		.page_bad(pbad), .rom_decode_en(rom_en), .rom_size_32k(rom32),
		.mem_size_code(size), .mem_size_bad(szbad),
		.clk_sel_internal(clk_int),
		.test_mode(tmode), .strap_done(done));
	initial
	begin
		forever #4 clk = ~clk;
	end
	task chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc_n++;
		if (cyc_n == 2000)
		begin
			n_fail++;
			final_report;
		end
	end
	task rst(input logic [23:0] s);
		@(posedge clk);
		strap <= s;
		sys_rst <= 1;
		repeat (5) @(posedge clk);
		#1 chk(ras_n, 2'h3);
		chk(ma_o, ADDR_IDLE);
		chk({oe_o, we_o, cas_o}, {OE_IDLE, 1'b1, CAS_IDLE});
		chk(done, 1'b0);
		chk(ctrl_oe, s[9]);
		@(posedge clk) sys_rst <= 0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk) reg_wr <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk) reg_rd <= 0;
		#1 chk(reg_rdata, e);
	endtask
	task cyc(input logic r, input logic p, input logic ea, input logic ec);
		@(posedge clk);
		{cyc_req, cyc_rom, cyc_pal_wr} <= {1'b1, r, p};
		@(posedge clk) cyc_req <= 0;
		#1 chk({acc, claim}, {ea, ec});
		@(posedge clk) #1 chk(rdy, ec);
	endtask
	task t_capture;
		rst(24'h60BB99);
		rd(8'h00, 8'h99);
		rd(8'h01, 8'hBB);
		rd(8'h02, 8'h06);
		chk({vl, edo, rom_en, size}, {3'h7, SIZE_2M});
		chk({clk_int, tmode, done}, 3'h5);
		chk({claim_oe, ready_oe, hbad, szbad}, 4'hC);
	endtask
	task t_hold;
		@(posedge clk);
		strap <= 24'h000000;
		pix_src_en <= 1;
		pix_src_data <= 24'h5A5A5A;
		mem_in <= 22'h15A5A5;
		repeat (3) @(posedge clk);
		#1 chk(pix_oe, 24'hFFFFFF);
		chk(pix_out, 24'h5A5A5A);
		chk({ma_o, oe_o, we_o, cas_o, ras_n}, 22'h15A5A5);
		chk(ctrl_oe, 1'b1);
		rd(8'h00, 8'h99);
	endtask
	task t_fields;
		logic [2:0] sz[4] = '{SIZE_4M, SIZE_2M, SIZE_1M, SIZE_HALF};
		logic [1:0] pg[4] = '{PAGE_EDO, PAGE_FAST, 2'h0, 2'h1};
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h00, {sz[i], 1'b1, pg[i], BUS_VL});
			rd(8'h00, {sz[i], 1'b1, pg[i], BUS_VL});
			@(posedge clk) #1 chk(size, sz[i]);
			chk({edo, fast, pbad}, {i == 0, i == 1, i > 1});
		end
	endtask
	task t_cycles;
		cyc(0, 0, 1, 1);
		cyc(0, 1, 1, 1);
		wr(8'h01, 8'hAA);
		cyc(0, 0, 0, 0);
		cyc(1, 0, 1, 1);
		wr(8'h01, 8'hAB);
		cyc(0, 1, 0, 0);
		wr(8'h00, 8'hE5);
		rd(8'h00, 8'hE5);
		chk(rom_en, 1'b0);
		rd(8'h10, 8'h00);
		wr(8'h03, 8'hFF);
		rd(8'h03, 8'h05);
		wr(8'h00, 8'h20);
		wr(8'h01, 8'h07);
		rd(8'h03, 8'h0D);
		chk({hbad, szbad, rom32, clk_int}, 4'hE);
	endtask
	task t_test;
		rst(24'h60B99A);
		chk({tmode, pci, ctrl_oe}, 3'h6);
		chk(pix_oe, 24'h000000);
		chk({claim_oe, ready_oe}, 2'h0);
		cyc(0, 0, 1, 0);
	endtask
	initial
	begin
		t_capture;
		t_hold;
		t_fields;
		t_cycles;
		t_test;
		final_report;
	end
endmodule
